// ==== bod_pkg.sv ====
// Constants, types and decode table for the byte opcode decoder
package bod_pkg;

  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [2:0] STEP_RESET = 3'h0;

  typedef enum logic [5:0] {
    C_NONE = 6'b000000,
    C_ADD_R = 6'b000001,
    C_ADD_DIR = 6'b000010,
    C_ADD_IMM = 6'b000011,
    C_ADDC_R = 6'b000100,
    C_ADDC_IMM = 6'b000101,
    C_SUBB_R = 6'b000110,
    C_SUBB_IMM = 6'b000111,
    C_ANL_R = 6'b001000,
    C_ANL_IMM = 6'b001001,
    C_ANL_DA = 6'b001010,
    C_ANL_DI = 6'b001011,
    C_ORL_R = 6'b001100,
    C_ORL_IMM = 6'b001101,
    C_ORL_DA = 6'b001110,
    C_ORL_DI = 6'b001111,
    C_XRL_R = 6'b010000,
    C_XRL_IMM = 6'b010001,
    C_XRL_DA = 6'b010010,
    C_XRL_DI = 6'b010011,
    C_RL = 6'b010100,
    C_RR = 6'b010101,
    C_RLC = 6'b010110,
    C_RRC = 6'b010111,
    C_SWAP = 6'b011000,
    C_ANL_CB = 6'b011001,
    C_ANL_CNB = 6'b011010,
    C_ORL_CB = 6'b011011,
    C_ORL_CNB = 6'b011100,
    C_MOV_BC = 6'b011101,
    C_MOV_CB = 6'b011110,
    C_MOV_DD = 6'b011111,
    C_MOV_PTR = 6'b100000,
    C_MOVC = 6'b100001,
    C_PUSH = 6'b100010,
    C_POP = 6'b100011,
    C_XCHD = 6'b100100,
    C_MOVX_WR = 6'b100101,
    C_XCH_R = 6'b100110
  } bod_class_e;

  typedef struct packed {
    bod_class_e cls;
    logic [2:0] len;
    logic [2:0] cyc;
  } bod_info_s;

  // Unlisted opcodes pass as one byte, one cycle, class none
  function automatic bod_info_s bod_decode(input logic [7:0] op, input logic flat);
    bod_info_s r;
    r = '{C_NONE, 3'h1, 3'h1};
    case (op) inside
      [8'h28:8'h2F]: r = '{C_ADD_R, 3'h1, 3'h1};
      8'h25: r = '{C_ADD_DIR, 3'h2, 3'h2};
      8'h24: r = '{C_ADD_IMM, 3'h2, 3'h2};
      [8'h38:8'h3F]: r = '{C_ADDC_R, 3'h1, 3'h1};
      8'h34: r = '{C_ADDC_IMM, 3'h2, 3'h2};
      [8'h98:8'h9F]: r = '{C_SUBB_R, 3'h1, 3'h1};
      8'h94: r = '{C_SUBB_IMM, 3'h2, 3'h2};
      [8'h58:8'h5F]: r = '{C_ANL_R, 3'h1, 3'h1};
      8'h54: r = '{C_ANL_IMM, 3'h2, 3'h2};
      8'h52: r = '{C_ANL_DA, 3'h2, 3'h3};
      8'h53: r = '{C_ANL_DI, 3'h3, 3'h3};
      [8'h48:8'h4F]: r = '{C_ORL_R, 3'h1, 3'h1};
      8'h44: r = '{C_ORL_IMM, 3'h2, 3'h2};
      8'h42: r = '{C_ORL_DA, 3'h2, 3'h3};
      8'h43: r = '{C_ORL_DI, 3'h3, 3'h3};
      [8'h68:8'h6F]: r = '{C_XRL_R, 3'h1, 3'h1};
      8'h64: r = '{C_XRL_IMM, 3'h2, 3'h2};
      8'h62: r = '{C_XRL_DA, 3'h2, 3'h3};
      8'h63: r = '{C_XRL_DI, 3'h3, 3'h3};
      8'h23: r = '{C_RL, 3'h1, 3'h1};
      8'h03: r = '{C_RR, 3'h1, 3'h1};
      8'h33: r = '{C_RLC, 3'h1, 3'h1};
      8'h13: r = '{C_RRC, 3'h1, 3'h1};
      8'hC4: r = '{C_SWAP, 3'h1, 3'h1};
      8'h82: r = '{C_ANL_CB, 3'h2, 3'h2};
      8'hB0: r = '{C_ANL_CNB, 3'h2, 3'h2};
      8'h72: r = '{C_ORL_CB, 3'h2, 3'h2};
      8'hA0: r = '{C_ORL_CNB, 3'h2, 3'h2};
      8'h92: r = '{C_MOV_BC, 3'h2, 3'h3};
      8'hA2: r = '{C_MOV_CB, 3'h2, 3'h2};
      8'h85: r = '{C_MOV_DD, 3'h3, 3'h3};
      8'h90:
      begin
        if (flat)
          r = '{C_MOV_PTR, 3'h4, 3'h4};
        else
          r = '{C_MOV_PTR, 3'h3, 3'h3};
      end
      8'h93: r = '{C_MOVC, 3'h1, 3'h5};
      8'hC0: r = '{C_PUSH, 3'h2, 3'h3};
      8'hD0: r = '{C_POP, 3'h2, 3'h2};
      [8'hD6:8'hD7]: r = '{C_XCHD, 3'h1, 3'h3};
      8'hF0: r = '{C_MOVX_WR, 3'h1, 3'h2};
      [8'hC8:8'hCF]: r = '{C_XCH_R, 3'h1, 3'h2};
      default: r = '{C_NONE, 3'h1, 3'h1};
    endcase
    return r;
  endfunction : bod_decode

endpackage : bod_pkg

// ==== bod_decoder.sv ====
// Opcode fetch, length and cycle sequencing for the byte core
`timescale 1ns/100ps
module bod_decoder
  import bod_pkg::*;
(
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CE,
  // Address model select
  input wire logic FLAT_MODE,
  // Program memory
  output logic [15:0] PM_ADDR,
  input wire logic [7:0] PM_DATA,
  // Decoded instruction
  output logic DONE,
  output logic UNKNOWN,
  output bod_class_e OP_CLASS,
  output logic [7:0] OP_CODE,
  output logic [2:0] REG_NUM,
  output logic [7:0] OPND_A,
  output logic [7:0] OPND_B,
  output logic [7:0] OPND_C,
  output logic [15:0] INSTR_PC
);

  logic [2:0] step_q;
  logic [15:0] pc_q;
  logic [15:0] start_q;
  logic [7:0] op_q;
  bod_info_s inf_q;
  bod_info_s inf_w;
  logic first_w;
  logic last_w;
  logic fetch_w;
  logic [7:0] cur_op_w;
  logic [7:0] opnd_q [3];
  logic [7:0] opnd_d [3];

  assign first_w = (step_q == STEP_RESET);
  // Length latched at the opcode so a mode change mid-instruction is harmless
  assign inf_w = first_w ? bod_decode(PM_DATA, FLAT_MODE) : inf_q;
  assign last_w = (step_q == inf_w.cyc - 3'h1);
  assign fetch_w = (step_q < inf_w.len);
  assign cur_op_w = first_w ? PM_DATA : op_q;
  assign PM_ADDR = pc_q;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      step_q <= STEP_RESET;
    else if (CE)
      step_q <= last_w ? STEP_RESET : step_q + 3'h1;
  end

  // One byte per cycle until the length is used up
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      pc_q <= RESET_PC;
    else if (CE && fetch_w)
      pc_q <= pc_q + 16'h0001;
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      start_q <= RESET_PC;
      op_q <= 8'h00;
      inf_q <= '{C_NONE, 3'h1, 3'h1};
    end
    else if (CE && first_w)
    begin
      start_q <= pc_q;
      op_q <= PM_DATA;
      inf_q <= inf_w;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_opnd
      // Last operand byte bypasses storage when it lands in the final cycle
      always_comb
      begin
        if (first_w)
          opnd_d[gi] = 8'h00;
        else if (fetch_w && step_q == 3'(gi + 1))
          opnd_d[gi] = PM_DATA;
        else
          opnd_d[gi] = opnd_q[gi];
      end
      always_ff @(posedge MCLK or negedge RSTN)
      begin
        if (!RSTN)
          opnd_q[gi] <= 8'h00;
        else if (CE)
          opnd_q[gi] <= opnd_d[gi];
      end
    end
  endgenerate

  // Frozen with the rest while CE is low, so DONE may stretch
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      DONE <= 1'b0;
      UNKNOWN <= 1'b0;
    end
    else if (CE)
    begin
      DONE <= last_w;
      UNKNOWN <= last_w && (inf_w.cls == C_NONE);
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      OP_CLASS <= C_NONE;
      OP_CODE <= 8'h00;
      REG_NUM <= 3'h0;
      OPND_A <= 8'h00;
      OPND_B <= 8'h00;
      OPND_C <= 8'h00;
      INSTR_PC <= RESET_PC;
    end
    else if (CE && last_w)
    begin
      OP_CLASS <= inf_w.cls;
      OP_CODE <= cur_op_w;
      // Indirect forms name the pointer register by one bit only
      if (inf_w.cls == C_XCHD)
        REG_NUM <= {2'b00, cur_op_w[0]};
      else
        REG_NUM <= cur_op_w[2:0];
      OPND_A <= opnd_d[0];
      OPND_B <= opnd_d[1];
      OPND_C <= opnd_d[2];
      INSTR_PC <= first_w ? pc_q : start_q;
    end
  end

  // Helper: cycles spent by the instruction just reported
  logic [2:0] hcnt_q;
  logic [2:0] hcyc_q;
  logic [2:0] blen_w;
  // Model of the reported instruction, since the pin may move on at DONE
  logic hflat_q;
  assign blen_w = 3'(pc_q - INSTR_PC);

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hcnt_q <= 3'h0;
      hcyc_q <= 3'h0;
      hflat_q <= 1'b0;
    end
    else if (CE)
    begin
      hcnt_q <= last_w ? 3'h0 : hcnt_q + 3'h1;
      if (last_w)
        hcyc_q <= hcnt_q + 3'h1;
      if (first_w)
        hflat_q <= FLAT_MODE;
    end
  end

  a_one_cycle_ops: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_ADD_R, C_ADDC_R, C_SUBB_R, C_ANL_R, C_ORL_R, C_XRL_R}
    |-> hcyc_q == 3'h1 && blen_w == 3'h1)
    else $error("register ALU op not one byte one cycle");

  a_rotate_swap: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_RL, C_RR, C_RLC, C_RRC, C_SWAP} |-> hcyc_q == 3'h1 && blen_w == 3'h1)
    else $error("rotate or swap not one byte one cycle");

  a_two_two_ops: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_ADD_DIR, C_ADD_IMM, C_ADDC_IMM, C_SUBB_IMM, C_ANL_IMM, C_ORL_IMM,
    C_XRL_IMM, C_ANL_CB, C_ANL_CNB, C_ORL_CB, C_ORL_CNB, C_MOV_CB, C_POP}
    |-> hcyc_q == 3'h2 && blen_w == 3'h2)
    else $error("two byte two cycle op timing wrong");

  a_two_three_ops: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_ANL_DA, C_ORL_DA, C_XRL_DA, C_MOV_BC, C_PUSH}
    |-> hcyc_q == 3'h3 && blen_w == 3'h2)
    else $error("two byte three cycle op timing wrong");

  a_three_byte_ops: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_ANL_DI, C_ORL_DI, C_XRL_DI, C_MOV_DD}
    |-> hcyc_q == 3'h3 && blen_w == 3'h3)
    else $error("three byte op timing wrong");

  a_pointer_load: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS == C_MOV_PTR |-> hcyc_q == blen_w && blen_w == (hflat_q ? 3'h4 : 3'h3))
    else $error("pointer load length wrong for model");

  a_one_byte_long: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && blen_w == 3'h1 |-> (OP_CLASS == C_MOVC) == (hcyc_q == 3'h5)
    && (OP_CLASS == C_XCHD) == (hcyc_q == 3'h3))
    else $error("code read or nibble exchange cycles wrong");

  a_exchange_reg: assert property (@(posedge MCLK) disable iff (!RSTN)
    DONE && OP_CLASS inside {C_XCH_R, C_MOVX_WR} |-> hcyc_q == 3'h2 && blen_w == 3'h1
    && (OP_CLASS == C_MOVX_WR || (OP_CODE[7:3] == 5'h19 && REG_NUM == OP_CODE[2:0])))
    else $error("register exchange decode wrong");

  a_fetch_order: assert property (@(posedge MCLK) disable iff (!RSTN)
    CE && fetch_w |=> PM_ADDR == $past(PM_ADDR) + 16'h0001)
    else $error("fetch address did not advance");

endmodule : bod_decoder

// ==== bod_pmem.sv ====
// Program memory model answering fetches by asynchronous byte read
`timescale 1ns/100ps
module bod_pmem
(
  // Fetch port
  input wire logic [15:0] PM_ADDR,
  output logic [7:0] PM_DATA
);
  logic [7:0] mem [0:255];
  // Only 256 bytes: upper address bits ignored, programs must stay short
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'hFF;
  end
  assign PM_DATA = mem[PM_ADDR[7:0]];
endmodule : bod_pmem

// ==== tb_top.sv ====
// Self-checking bench for the byte opcode decoder
`timescale 1ns/100ps
module tb_top
  import bod_pkg::*;
();
  logic mclk, rstn, ce, flat_mode, done, unknown;
  logic [15:0] pm_addr, instr_pc, pc;
  logic [7:0] pm_data, op_code, opnd_a, opnd_b, opnd_c;
  logic [2:0] reg_num;
  bod_class_e op_class;
  int errors = 0;
  int compares = 0;

  bod_decoder dut_u (.MCLK(mclk), .RSTN(rstn), .CE(ce), .FLAT_MODE(flat_mode), .PM_ADDR(pm_addr),
    .PM_DATA(pm_data), .DONE(done), .UNKNOWN(unknown), .OP_CLASS(op_class), .OP_CODE(op_code),
    .REG_NUM(reg_num), .OPND_A(opnd_a), .OPND_B(opnd_b), .OPND_C(opnd_c), .INSTR_PC(instr_pc));
  bod_pmem pm_u (.PM_ADDR(pm_addr), .PM_DATA(pm_data));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Called at the falling edge before the opcode edge; leaves at the DONE cycle
  task exec(input logic [7:0] op, input int len, input int cyc, input bod_class_e cls, input bit stall);
    logic [7:0] v [1:3];
    pm_u.mem[pc[7:0]] = op;
    for (int k = 1; k < 4; k++)
    begin
      v[k] = (k < len) ? ((pc[7:0] + 8'(k)) ^ 8'hC3) : 8'h00;
      if (k < len)
        pm_u.mem[8'(pc + 16'(k))] = v[k];
    end
    for (int k = 1; k <= cyc; k++)
    begin
      @(negedge mclk);
      if (stall && k == 1)
      begin
        ce = 1'b0;
        repeat (3) @(negedge mclk);
        chk(pm_addr, pc + 16'h0001);
        chk(done, 1'b0);
        ce = 1'b1;
      end
      chk(pm_addr, pc + 16'((k < len) ? k : len));
      chk(done, k == cyc);
    end
    chk(op_code, op);
    chk(op_class, cls);
    chk(unknown, cls == C_NONE);
    chk(instr_pc, pc);
    chk(reg_num, (cls == C_XCHD) ? {2'b00, op[0]} : op[2:0]);
    chk(opnd_a, v[1]);
    chk(opnd_b, v[2]);
    chk(opnd_c, v[3]);
    pc = pc + 16'(len);
  endtask : exec

  task run(input logic [7:0] lo, input logic [7:0] hi, input int len, input int cyc, input bod_class_e cls);
    for (int o = lo; o <= hi; o++)
      exec(8'(o), len, cyc, cls, 1'b0);
  endtask : run

  // Every decoded row except the pointer load back to back, plus opcodes outside the table
  task t_table;
    run(8'h28, 8'h2F, 1, 1, C_ADD_R);
    run(8'h25, 8'h25, 2, 2, C_ADD_DIR);
    run(8'h24, 8'h24, 2, 2, C_ADD_IMM);
    run(8'h38, 8'h3F, 1, 1, C_ADDC_R);
    run(8'h34, 8'h34, 2, 2, C_ADDC_IMM);
    run(8'h98, 8'h9F, 1, 1, C_SUBB_R);
    run(8'h94, 8'h94, 2, 2, C_SUBB_IMM);
    run(8'h58, 8'h5F, 1, 1, C_ANL_R);
    run(8'h54, 8'h54, 2, 2, C_ANL_IMM);
    run(8'h52, 8'h52, 2, 3, C_ANL_DA);
    run(8'h53, 8'h53, 3, 3, C_ANL_DI);
    run(8'h48, 8'h4F, 1, 1, C_ORL_R);
    run(8'h44, 8'h44, 2, 2, C_ORL_IMM);
    run(8'h42, 8'h42, 2, 3, C_ORL_DA);
    run(8'h43, 8'h43, 3, 3, C_ORL_DI);
    run(8'h68, 8'h6F, 1, 1, C_XRL_R);
    run(8'h64, 8'h64, 2, 2, C_XRL_IMM);
    run(8'h62, 8'h62, 2, 3, C_XRL_DA);
    run(8'h63, 8'h63, 3, 3, C_XRL_DI);
    run(8'h23, 8'h23, 1, 1, C_RL);
    run(8'h03, 8'h03, 1, 1, C_RR);
    run(8'h33, 8'h33, 1, 1, C_RLC);
    run(8'h13, 8'h13, 1, 1, C_RRC);
    run(8'hC4, 8'hC4, 1, 1, C_SWAP);
    run(8'h82, 8'h82, 2, 2, C_ANL_CB);
    run(8'hB0, 8'hB0, 2, 2, C_ANL_CNB);
    run(8'h72, 8'h72, 2, 2, C_ORL_CB);
    run(8'hA0, 8'hA0, 2, 2, C_ORL_CNB);
    run(8'h92, 8'h92, 2, 3, C_MOV_BC);
    run(8'hA2, 8'hA2, 2, 2, C_MOV_CB);
    run(8'h85, 8'h85, 3, 3, C_MOV_DD);
    run(8'h93, 8'h93, 1, 5, C_MOVC);
    run(8'hC0, 8'hC0, 2, 3, C_PUSH);
    run(8'hD0, 8'hD0, 2, 2, C_POP);
    run(8'hD6, 8'hD7, 1, 3, C_XCHD);
    run(8'hF0, 8'hF0, 1, 2, C_MOVX_WR);
    run(8'hC8, 8'hCF, 1, 2, C_XCH_R);
    run(8'hE4, 8'hE5, 1, 1, C_NONE);
  endtask : t_table

  // Pointer load length follows the model latched at the opcode
  task t_flat;
    flat_mode = 1'b1;
    run(8'h90, 8'h90, 4, 4, C_MOV_PTR);
    flat_mode = 1'b0;
    run(8'h90, 8'h90, 3, 3, C_MOV_PTR);
  endtask : t_flat

  // Stall in mid-fetch and in the idle tail of a long instruction
  task t_stall;
    exec(8'h53, 3, 3, C_ANL_DI, 1'b1);
    exec(8'h93, 1, 5, C_MOVC, 1'b1);
  endtask : t_stall

  // Second reset right at a DONE cycle, then restart from address zero
  task t_reset;
    exec(8'h85, 3, 3, C_MOV_DD, 1'b0);
    rstn = 1'b0;
    #1;
    chk(pm_addr, 16'h0000);
    chk(done, 1'b0);
    chk(unknown, 1'b0);
    chk(op_class, C_NONE);
    chk(opnd_a, 8'h00);
    chk(instr_pc, 16'h0000);
    @(negedge mclk);
    rstn = 1'b1;
    pc = 16'h0000;
    exec(8'h43, 3, 3, C_ORL_DI, 1'b0);
  endtask : t_reset

  task end_of_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    pc = 16'h0000;
    rstn = 1'b0;
    ce = 1'b1;
    flat_mode = 1'b0;
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    t_table;
    t_flat;
    t_stall;
    t_reset;
    end_of_test;
  end

  // About 170 cycles expected; generous margin
  initial
  begin
    #50000;
    errors++;
    end_of_test;
  end
endmodule : tb_top
